/* File: xbt_trigger.sv */
// extended breakpoint trigger: second comparator set and trigger sequencer
`timescale 1ns/1ns
module xbt_trigger (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// debug register write by supervisor instruction
	input  wire logic        instr_wr,
	input  wire logic [7:0]  instr_reg_num,
	input  wire logic [31:0] instr_wdata,
	// debug register write by background debug port command
	input  wire logic        port_wr,
	input  wire logic [7:0]  port_reg_num,
	input  wire logic [31:0] port_wdata,
	// primary trigger register contents and its write strobe
	input  wire logic [31:0] primary_trigger_definition,
	input  wire logic        primary_wr,
	// primary comparators: pc set and first address terms per level
	input  wire logic        pc_cmp_masked,
	input  wire logic [2:0]  pc_cmp_extra,
	input  wire logic [1:0]  first_addr_term,
	// processor local bus
	input  wire logic        bus_valid,
	input  wire logic [31:0] bus_addr,
	input  wire logic [7:0]  bus_attr,
	input  wire logic [31:0] bus_data,
	// results
	output logic [31:0]      extended_trigger_definition,
	output logic             status_clear,
	output logic             trigger_hit,
	output logic             second_level_armed
);

	logic        rst_meta;
	logic        rst_n;
	logic [31:0] second_addr_high;
	logic [31:0] second_addr_low;
	logic [31:0] second_addr_attributes;
	logic [31:0] second_data_value;
	logic [31:0] second_data_mask;
	logic [31:0] next_ext_def;
	logic [31:0] next_addr_high;
	logic [31:0] next_addr_low;
	logic [31:0] next_addr_attr;
	logic [31:0] next_data_value;
	logic [31:0] next_data_mask;
	logic        wr_any;
	logic [7:0]  wr_num;
	logic [31:0] wr_data;
	logic        ext_written;
	logic        next_status_clear;
	xbt_pkg::xbt_seq_t seq_state;
	xbt_pkg::xbt_seq_t next_seq_state;
	logic        next_trigger_hit;
	logic        pc_term;
	logic [1:0]  level_on;
	logic [1:0]  level_term;
	logic [1:0]  sec_addr_en;
	logic [1:0]  sec_addr_hit;
	logic [1:0]  sec_data_en;
	logic [1:0]  sec_data_hit;
	logic [15:0] ext_half [2];
	logic [15:0] prim_half [2];

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// register write decode; port command wins a same-cycle collision
	always_comb begin
		wr_any = instr_wr | port_wr;
		wr_num = port_wr ? port_reg_num : instr_reg_num;
		wr_data = port_wr ? port_wdata : instr_wdata;
		ext_written = wr_any && (wr_num == xbt_pkg::REG_EXT_TRIGGER_DEF);
		next_ext_def = extended_trigger_definition;
		next_addr_high = second_addr_high;
		next_addr_low = second_addr_low;
		next_addr_attr = second_addr_attributes;
		next_data_value = second_data_value;
		next_data_mask = second_data_mask;
		next_status_clear = ext_written;
		if (ext_written) begin
			next_ext_def = wr_data & xbt_pkg::EXT_TRIGGER_WRITE_MASK;
		end
		if (wr_any && wr_num == xbt_pkg::REG_SECOND_ADDR_HIGH) begin
			next_addr_high = wr_data;
		end
		if (wr_any && wr_num == xbt_pkg::REG_SECOND_ADDR_LOW) begin
			next_addr_low = wr_data;
		end
		if (wr_any && wr_num == xbt_pkg::REG_SECOND_ADDR_ATTR) begin
			next_addr_attr = wr_data;
		end
		if (wr_any && wr_num == xbt_pkg::REG_SECOND_DATA_VALUE) begin
			next_data_value = wr_data;
		end
		if (wr_any && wr_num == xbt_pkg::REG_SECOND_DATA_MASK) begin
			next_data_mask = wr_data;
		end
	end

	// register storage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			extended_trigger_definition <= xbt_pkg::EXT_TRIGGER_RESET;
			second_addr_high <= xbt_pkg::SECOND_REG_RESET;
			second_addr_low <= xbt_pkg::SECOND_REG_RESET;
			second_addr_attributes <= xbt_pkg::SECOND_REG_RESET;
			second_data_value <= xbt_pkg::SECOND_REG_RESET;
			second_data_mask <= xbt_pkg::SECOND_REG_RESET;
			status_clear <= 1'b0;
		end else begin
			extended_trigger_definition <= next_ext_def;
			second_addr_high <= next_addr_high;
			second_addr_low <= next_addr_low;
			second_addr_attributes <= next_addr_attr;
			second_data_value <= next_data_value;
			second_data_mask <= next_data_mask;
			status_clear <= next_status_clear;
		end
	end

	// split both trigger registers into first and second level halves
	always_comb begin
		ext_half[0] = extended_trigger_definition[xbt_pkg::LVL_FIRST_BASE
			+: xbt_pkg::LVL_HALF_W];
		ext_half[1] = extended_trigger_definition[xbt_pkg::LVL_SECOND_BASE +: xbt_pkg::LVL_HALF_W];
		prim_half[0] = primary_trigger_definition[xbt_pkg::LVL_FIRST_BASE +: xbt_pkg::LVL_HALF_W];
		prim_half[1] = primary_trigger_definition[xbt_pkg::LVL_SECOND_BASE +: xbt_pkg::LVL_HALF_W];
		pc_term = pc_cmp_masked | (|pc_cmp_extra);
	end

	// per level: second comparator set plus combination with primary terms
	genvar lv;
	generate
		for (lv = 0; lv < 2; lv++) begin : g_level
			xbt_match_unit u_match (
				.level_def    (ext_half[lv]),
				.addr_high    (second_addr_high),
				.addr_low     (second_addr_low),
				.addr_attr    (second_addr_attributes),
				.data_value   (second_data_value),
				.data_mask    (second_data_mask),
				.bus_valid    (bus_valid),
				.bus_addr     (bus_addr),
				.bus_attr     (bus_attr),
				.bus_data     (bus_data),
				.addr_enabled (sec_addr_en[lv]),
				.addr_hit     (sec_addr_hit[lv]),
				.data_enabled (sec_data_en[lv]),
				.data_hit     (sec_data_hit[lv])
			);
			always_comb begin
				level_on[lv] = prim_half[lv][xbt_pkg::FLD_GLOBAL_ENABLE]
					| ext_half[lv][xbt_pkg::FLD_GLOBAL_ENABLE];
				level_term[lv] = (prim_half[lv][xbt_pkg::FLD_PC_ENABLE]
						& (pc_term ^ prim_half[lv][xbt_pkg::FLD_PC_INVERT]))
					| first_addr_term[lv]
					| (sec_addr_en[lv] & sec_addr_hit[lv]
						& (~sec_data_en[lv] | sec_data_hit[lv]));
			end
		end
	endgenerate

	// trigger sequencer: one level, or first then second level
	always_comb begin
		next_seq_state = seq_state;
		next_trigger_hit = 1'b0;
		if (ext_written || (wr_any && primary_wr) || primary_wr) begin
			next_seq_state = xbt_pkg::SEQ_WAIT_FIRST;
		end else begin
			unique case (seq_state)
				xbt_pkg::SEQ_WAIT_FIRST: begin
					if (level_on == 2'b11) begin
						if (level_term[0]) begin
							next_seq_state = xbt_pkg::SEQ_WAIT_SECOND;
						end
					end else if (level_on == 2'b01) begin
						next_trigger_hit = level_term[0];
					end else if (level_on == 2'b10) begin
						next_trigger_hit = level_term[1];
					end
				end
				xbt_pkg::SEQ_WAIT_SECOND: begin
					if (level_on != 2'b11) begin
						next_seq_state = xbt_pkg::SEQ_WAIT_FIRST;
					end else if (level_term[1]) begin
						next_trigger_hit = 1'b1;
						next_seq_state = xbt_pkg::SEQ_WAIT_FIRST;
					end
				end
				default: begin
					next_seq_state = xbt_pkg::SEQ_WAIT_FIRST;
				end
			endcase
		end
	end

	// sequencer and trigger output flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seq_state <= xbt_pkg::SEQ_WAIT_FIRST;
			trigger_hit <= 1'b0;
			second_level_armed <= 1'b0;
		end else begin
			seq_state <= next_seq_state;
			trigger_hit <= next_trigger_hit;
			second_level_armed <= (next_seq_state == xbt_pkg::SEQ_WAIT_SECOND);
		end
	end

endmodule

/* File: xbt_pkg.sv */
// constants and types for the extended breakpoint trigger block
package xbt_pkg;

	// debug control register numbers
	localparam logic [7:0] REG_EXT_TRIGGER_DEF = 8'h17;
	localparam logic [7:0] REG_SECOND_ADDR_HIGH = 8'h1a;
	localparam logic [7:0] REG_SECOND_ADDR_LOW = 8'h1b;
	localparam logic [7:0] REG_SECOND_ADDR_ATTR = 8'h1c;
	localparam logic [7:0] REG_SECOND_DATA_VALUE = 8'h1d;
	localparam logic [7:0] REG_SECOND_DATA_MASK = 8'h1e;

	// trigger definition half-word layout (same in both halves)
	localparam int LVL_HALF_W = 16;
	localparam int LVL_SECOND_BASE = 16;
	localparam int LVL_FIRST_BASE = 0;
	localparam int FLD_GLOBAL_ENABLE = 13;
	localparam int FLD_DATA_ENABLE_LSB = 6;
	localparam int FLD_DATA_ENABLE_W = 7;
	localparam int FLD_DATA_INVERT = 5;
	localparam int FLD_ADDR_OUTSIDE = 4;
	localparam int FLD_ADDR_INSIDE = 3;
	localparam int FLD_ADDR_LOW = 2;
	localparam int FLD_PC_ENABLE = 1;
	localparam int FLD_PC_INVERT = 0;

	// data lane index inside the data enable field
	localparam int LANE_BYTE3 = 0;
	localparam int LANE_BYTE2 = 1;
	localparam int LANE_BYTE1 = 2;
	localparam int LANE_BYTE0 = 3;
	localparam int LANE_HIGH_HALF = 4;
	localparam int LANE_LOW_HALF = 5;
	localparam int LANE_FULL_LONG = 6;

	// writable bits of the extended trigger register; reserved bits read zero
	localparam logic [31:0] EXT_TRIGGER_WRITE_MASK = 32'h3ffc_3ffc;

	// attribute register layout: low byte value, next byte don't-care mask
	localparam int ATTR_W = 8;
	localparam int ATTR_MASK_LSB = 8;

	// reset values
	localparam logic [31:0] EXT_TRIGGER_RESET = 32'h0000_0000;
	localparam logic [31:0] SECOND_REG_RESET = 32'h0000_0000;

	// two-level trigger sequencer states
	typedef enum logic [1:0] {
		SEQ_WAIT_FIRST  = 2'b01,
		SEQ_WAIT_SECOND = 2'b10
	} xbt_seq_t;

endpackage

/* File: xbt_match_unit.sv */
// second comparator set evaluated against one trigger level's half-word
`timescale 1ns/1ns
module xbt_match_unit (
	// level controls
	input  wire logic [15:0] level_def,
	// second comparator registers
	input  wire logic [31:0] addr_high,
	input  wire logic [31:0] addr_low,
	input  wire logic [31:0] addr_attr,
	input  wire logic [31:0] data_value,
	input  wire logic [31:0] data_mask,
	// local bus
	input  wire logic        bus_valid,
	input  wire logic [31:0] bus_addr,
	input  wire logic [7:0]  bus_attr,
	input  wire logic [31:0] bus_data,
	// results
	output logic             addr_enabled,
	output logic             addr_hit,
	output logic             data_enabled,
	output logic             data_hit
);

	logic [31:0] bit_equal;
	logic [6:0]  lane_equal;
	logic [6:0]  lane_result;
	logic [6:0]  lane_enable;
	logic        attr_ok;
	logic        in_range;
	logic        low_equal;
	logic        mode_out;
	logic        mode_in;
	logic        mode_low;

	// address comparison with attribute qualification
	always_comb begin
		mode_out = level_def[xbt_pkg::FLD_ADDR_OUTSIDE];
		mode_in = level_def[xbt_pkg::FLD_ADDR_INSIDE];
		mode_low = level_def[xbt_pkg::FLD_ADDR_LOW];
		attr_ok = ((bus_attr ^ addr_attr[xbt_pkg::ATTR_W-1:0])
			& ~addr_attr[xbt_pkg::ATTR_MASK_LSB +: xbt_pkg::ATTR_W]) == 8'h00;
		in_range = (bus_addr >= addr_low) && (bus_addr <= addr_high);
		low_equal = (bus_addr == addr_low);
		addr_enabled = mode_out | mode_in | mode_low;
		addr_hit = bus_valid & attr_ok & ((mode_out & ~in_range)
			| (mode_in & in_range) | (mode_low & low_equal));
	end

	// data comparison per lane; mask bit set means don't care
	always_comb begin
		bit_equal = ~((bus_data ^ data_value) & ~data_mask);
		lane_equal[xbt_pkg::LANE_FULL_LONG] = &bit_equal;
		lane_equal[xbt_pkg::LANE_LOW_HALF] = &bit_equal[15:0];
		lane_equal[xbt_pkg::LANE_HIGH_HALF] = &bit_equal[31:16];
		lane_equal[xbt_pkg::LANE_BYTE0] = &bit_equal[7:0];
		lane_equal[xbt_pkg::LANE_BYTE1] = &bit_equal[15:8];
		lane_equal[xbt_pkg::LANE_BYTE2] = &bit_equal[23:16];
		lane_equal[xbt_pkg::LANE_BYTE3] = &bit_equal[31:24];
		lane_enable = level_def[xbt_pkg::FLD_DATA_ENABLE_LSB +: xbt_pkg::FLD_DATA_ENABLE_W];
		lane_result = lane_equal ^ {7{level_def[xbt_pkg::FLD_DATA_INVERT]}};
		data_enabled = |lane_enable;
		data_hit = bus_valid & |(lane_enable & lane_result);
	end

endmodule

/* File: xbt_bus_model.sv */
// local bus partner model for the extended breakpoint trigger
`timescale 1ns/1ns
module xbt_bus_model (
	// request from the bench
	input  wire logic        go,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] data,
	// processor local bus
	output logic             bus_valid,
	output logic [31:0]      bus_addr,
	output logic [7:0]       bus_attr,
	output logic [31:0]      bus_data
);
	// idle bus shows the inverse, never a stale copy of the last cycle
	assign bus_valid = go;
	assign bus_addr  = go ? addr : ~addr;
	assign bus_data  = go ? data : ~data;
	assign bus_attr  = go ? 8'h05 : 8'hfa;
endmodule

/* File: xbt_trigger_checker.sv */
// port assertions for the extended breakpoint trigger
`timescale 1ns/1ns
module xbt_trigger_checker (
	// clock, reset and writes
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        instr_wr,
	input wire logic [7:0]  instr_reg_num,
	input wire logic        port_wr,
	input wire logic [7:0]  port_reg_num,
	input wire logic [31:0] port_wdata,
	// primary side
	input wire logic [31:0] primary_trigger_definition,
	input wire logic        primary_wr,
	input wire logic        pc_cmp_masked,
	// results
	input wire logic [31:0] extended_trigger_definition,
	input wire logic        status_clear,
	input wire logic        trigger_hit,
	input wire logic        second_level_armed
);
	logic [31:0] pt, xt;
	logic        w17, anyw, en, en2;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// write decode (port wins) and level enables
	assign pt = primary_trigger_definition;
	assign xt = extended_trigger_definition;
	assign w17 = port_wr ? port_reg_num == 8'h17 : instr_wr && instr_reg_num == 8'h17;
	assign anyw = w17 || primary_wr;
	assign en = pt[13] || pt[29] || xt[13] || xt[29];
	assign en2 = (pt[13] || xt[13]) && (pt[29] || xt[29]);
	property p_clear;
		status_clear == $past(w17);
	endproperty
	a_clear: assert property (p_clear) else $error("status pulse wrong");
	property p_port_data;
		port_wr && port_reg_num == 8'h17 |=> xt == ($past(port_wdata) & 32'h3ffc_3ffc);
	endproperty
	a_port_data: assert property (p_port_data) else $error("readback wrong");
	property p_hold;
		!w17 |=> $stable(xt);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed");
	property p_reserved;
		xt[17:16] == 2'b00 && xt[1:0] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved set");
	property p_disabled;
		!en |=> !trigger_hit;
	endproperty
	a_disabled: assert property (p_disabled) else $error("hit while off");
	property p_suppress;
		anyw |=> !trigger_hit && !second_level_armed;
	endproperty
	a_suppress: assert property (p_suppress) else $error("not restarted");
	property p_pc_one;
		pt[13] && pt[1] && !pt[0] && !pt[29] && !xt[29] && pc_cmp_masked && !anyw |=> trigger_hit;
	endproperty
	a_pc_one: assert property (p_pc_one) else $error("pc hit missed");
	property p_armed;
		second_level_armed |-> $past(en2);
	endproperty
	a_armed: assert property (p_armed) else $error("armed off mode");
	c_write: cover property (w17 ##1 status_clear);
	c_hit: cover property (trigger_hit);
	c_two: cover property (second_level_armed ##1 trigger_hit);
endmodule

/* File: xbt_trigger_bench.sv */
// self-checking bench for the extended breakpoint trigger
`timescale 1ns/1ns
module xbt_trigger_bench;
	logic clk_sys = 0, resetn = 0, instr_wr = 0, port_wr = 0, primary_wr = 0, go = 0;
	logic pc_cmp_masked = 0, bus_valid, status_clear, trigger_hit, second_level_armed;
	logic [2:0] pc_cmp_extra = 0;
	logic [1:0] first_addr_term = 0;
	logic [7:0] instr_reg_num = 0, port_reg_num = 0, bus_attr;
	logic [31:0] instr_wdata = 0, port_wdata = 0, prim = 0, ba = 0, bd = 0, bus_addr, bus_data;
	logic [31:0] extended_trigger_definition, xe = 0, d, lm;
	logic [31:0] av [3] = '{32'h1800, 32'h3000, 32'h1000};
	int n_errors = 0, total_checks = 0, cycles = 0, seed = 32'hbd11a3f0;
	xbt_trigger dut_u (
		.clk_sys                     (clk_sys),
		.resetn                      (resetn),
		.instr_wr                    (instr_wr),
		.instr_reg_num               (instr_reg_num),
		.instr_wdata                 (instr_wdata),
		.port_wr                     (port_wr),
		.port_reg_num                (port_reg_num),
		.port_wdata                  (port_wdata),
		.primary_trigger_definition  (prim),
		.primary_wr                  (primary_wr),
		.pc_cmp_masked               (pc_cmp_masked),
		.pc_cmp_extra                (pc_cmp_extra),
		.first_addr_term             (first_addr_term),
		.bus_valid                   (bus_valid),
		.bus_addr                    (bus_addr),
		.bus_attr                    (bus_attr),
		.bus_data                    (bus_data),
		.extended_trigger_definition (extended_trigger_definition),
		.status_clear                (status_clear),
		.trigger_hit                 (trigger_hit),
		.second_level_armed          (second_level_armed)
	);
	xbt_bus_model bus_u (.go, .addr(ba), .data(bd), .bus_valid, .bus_addr, .bus_attr, .bus_data);
	always #25 clk_sys = ~clk_sys;
	// cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 1000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic test_done();
		if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// one register write, readback and status pulse compared
	task automatic wr(input logic p, input logic [7:0] num, input logic [31:0] v);
		if (p) {port_wr, port_reg_num, port_wdata} = {1'b1, num, v};
		else {instr_wr, instr_reg_num, instr_wdata} = {1'b1, num, v};
		if (num == 8'h17) xe = v & 32'h3ffc_3ffc;
		nc(1);
		port_wr = 0;
		instr_wr = 0;
		chk(extended_trigger_definition, xe);
		chk(status_clear, num == 8'h17);
		nc(1);
	endtask
	// one bus and pc cycle, hit compared after the next edge
	task automatic trig(input logic g, input logic [3:0] pc, input logic [31:0] a, dt, input logic e);
		{go, pc_cmp_extra, pc_cmp_masked, ba, bd} = {g, pc, a, dt};
		nc(1);
		chk(trigger_hit, e);
	endtask
	function automatic logic exp_addr(input int m, input int j);
		return (m == 2 && j == 2) || (m == 3 && j == 0) || (m == 4 && j == 1);
	endfunction
	function automatic logic [31:0] lane_mask(input int l);
		case (l)
			0: return 32'hff00_0000;
			1: return 32'h00ff_0000;
			2: return 32'h0000_ff00;
			3: return 32'h0000_00ff;
			4: return 32'hffff_0000;
			5: return 32'h0000_ffff;
			default: return 32'hffff_ffff;
		endcase
	endfunction
	initial begin
		nc(5);
		resetn = 1;
		nc(3);
		chk(extended_trigger_definition, 0);
		// random writes by both paths, then an unmapped number
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			wr(i[0], 8'h17, d);
		end
		wr(0, 8'h55, 32'hffff_ffff);
		// random contents cleared so the modes below are known
		wr(1, 8'h17, 0);
		// one-level pc terms, inverted pc, then enable taken from either register
		prim = 32'h0000_2002;
		for (int k = 0; k < 4; k++) trig(0, 4'h1 << k, 0, 0, 1);
		prim = 32'h0000_2003;
		trig(0, 4'h0, 0, 0, 1);
		trig(0, 4'h2, 0, 0, 0);
		prim = 32'h0000_0002;
		trig(0, 4'h1, 0, 0, 0);
		wr(0, 8'h17, 32'h0000_2000);
		trig(0, 4'h1, 0, 0, 1);
		first_addr_term = 2'b01;
		trig(0, 0, 0, 0, 1);
		first_addr_term = 0;
		wr(1, 8'h17, 0);
		trig(0, 4'h1, 0, 0, 0);
		// second address modes: low alone, inside, outside
		prim = 0;
		wr(1, 8'h1b, 32'h1000);
		wr(0, 8'h1a, 32'h1fff);
		wr(1, 8'h1c, 32'hff00);
		for (int m = 2; m < 5; m++) begin
			wr(m[0], 8'h17, 32'h2000 | (1 << m));
			for (int j = 0; j < (m == 2 ? 3 : 2); j++) trig(1, 0, av[j], 0, exp_addr(m, j));
		end
		// attribute value compared with no don't-care bits
		wr(0, 8'h1c, 32'h0003);
		trig(1, 0, 32'h3000, 0, 0);
		wr(1, 8'h1c, 32'h0005);
		trig(1, 0, 32'h3000, 0, 1);
		// data lanes plain and inverted, anded with the low address match
		d = $random(seed);
		wr(0, 8'h1d, d);
		wr(1, 8'h1e, 0);
		for (int k = 0; k < 14; k++) begin
			lm = lane_mask(k % 7);
			wr(k[0], 8'h17, 32'h2004 | (32'h40 << (k % 7)) | ((k / 7) << 5));
			trig(1, 0, 32'h1000, d ^ ~lm, k < 7);
			trig(1, 0, 32'h1000, d ^ (lm & -lm), k >= 7);
			trig(1, 0, 32'h1800, d ^ ~lm, 0);
		end
		// one level in the upper half alone
		wr(1, 8'h17, 32'h2004_0000);
		trig(1, 0, 32'h1000, 0, 1);
		// two-level: low address arms, pc in the upper half fires
		trig(0, 0, 0, 0, 0);
		prim = 32'h0002_0000;
		wr(0, 8'h17, 32'h2000_2004);
		trig(0, 4'h1, 0, 0, 0);
		trig(1, 0, 32'h1000, 0, 0);
		chk(second_level_armed, 1);
		trig(0, 4'h1, 0, 0, 1);
		chk(second_level_armed, 0);
		trig(1, 0, 32'h1000, 0, 0);
		primary_wr = 1;
		trig(0, 0, 0, 0, 0);
		primary_wr = 0;
		chk(second_level_armed, 0);
		trig(0, 4'h1, 0, 0, 0);
		// reset in mid-run
		resetn = 0;
		nc(2);
		chk(extended_trigger_definition, 0);
		chk(second_level_armed, 0);
		resetn = 1;
		nc(3);
		test_done();
	end
endmodule
bind xbt_trigger xbt_trigger_checker chk_u (
	.clk_sys                     (clk_sys),
	.resetn                      (resetn),
	.instr_wr                    (instr_wr),
	.instr_reg_num               (instr_reg_num),
	.port_wr                     (port_wr),
	.port_reg_num                (port_reg_num),
	.port_wdata                  (port_wdata),
	.primary_trigger_definition  (primary_trigger_definition),
	.primary_wr                  (primary_wr),
	.pc_cmp_masked               (pc_cmp_masked),
	.extended_trigger_definition (extended_trigger_definition),
	.status_clear                (status_clear),
	.trigger_hit                 (trigger_hit),
	.second_level_armed          (second_level_armed)
);
